// File: logic/tcs_pkg.sv
// Package for the DMA channel request sequencer.
// Assumes a single 200 MHz clock and an Avalon-MM register slave.
package tcs_pkg;
	localparam int TCS_NCH = 4;
	// Channel register block: base = channel * 0x10.
	localparam logic [7:0] TCS_SRC_OFS   = 8'h00;
	localparam logic [7:0] TCS_DST_OFS   = 8'h04;
	localparam logic [7:0] TCS_CNT_OFS   = 8'h08;
	localparam logic [7:0] TCS_CTL_OFS   = 8'h0c;
	localparam logic [7:0] TCS_OPC_ADDR  = 8'h40;
	localparam logic [7:0] TCS_IST_ADDR  = 8'h44;
	localparam logic [7:0] TCS_IMSK_ADDR = 8'h48;
	localparam logic [7:0] TCS_EVT_ADDR  = 8'h4c;
	// Channel control field positions.
	localparam int TCS_CTL_CE  = 0;
	localparam int TCS_CTL_TE  = 1;
	localparam int TCS_CTL_IE  = 2;
	localparam int TCS_CTL_DS  = 3;
	localparam int TCS_CTL_TS  = 4;
	localparam int TCS_CTL_RS  = 8;
	// Operation control field positions.
	localparam int TCS_OPC_GE  = 0;
	localparam int TCS_OPC_NMI = 1;
	localparam int TCS_OPC_AE  = 2;
	localparam int TCS_OPC_COD = 4;
	localparam int TCS_OPC_PR  = 8;
	// Request source encodings.
	localparam logic [3:0] TCS_RS_EXT_DUAL = 4'h0;
	localparam logic [3:0] TCS_RS_EXT_M2A  = 4'h2;
	localparam logic [3:0] TCS_RS_EXT_A2M  = 4'h3;
	localparam logic [3:0] TCS_RS_AUTO     = 4'h4;
	localparam logic [31:0] TCS_RESET_VAL  = 32'h0000_0000;
	typedef enum logic [1:0] {
		TCS_IDLE,
		TCS_MOVE,
		TCS_DONE
	} tcs_state_t;
endpackage

// File: logic/tcs_sequencer.sv
// DMA channel request sequencer: four channels, one transfer engine.
// Assumes an Avalon-MM master, synchronous request pins, and an outside
// mover that takes one unit per move_start_o and reports move_done_i.
//
// Summary of operation
// - Simultaneous requests are served in configured channel priority order.
// - Channel eligible only with both enables set and no end/NMI/AE flag.
// - Each accepted request moves one unit and decrements the count by one.
// - Count reaching zero ends normally; interrupt if end interrupt enabled.
// - Address error, NMI or a cleared enable suspends transfer.
// - Address error always raises the address error interrupt.
// - Requests while disabled wait and start once everything is enabled.
// - Automatic mode requests internally whenever the channel is eligible.
// - Four-bit request source field selects auto, external or peripheral.
// - Requests from third-party agents are served the same way.
// - Channels 0 and 1 sense select: 0 low level, 1 falling edge.
// - External encodings 0000 dual, 0010 memory to device, 0011 reverse.
// - After reset requests are accepted but run only once enabled.
// - Edge requests taken while disabled are latched until run or cancel.
// - External requests ignored while end, NMI or AE flag set or in standby.
// - Latched requests drop on NMI flag, address error flag or reset.
`timescale 1ns/1ps
module tcs_sequencer
	import tcs_pkg::*;
#(
	parameter int CNT_W = 24
) (
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic [3:0]  external_request_n_i,
	input  wire logic [3:0]  periph_request_i,
	input  wire logic        nmi_i,
	input  wire logic        standby_i,
	input  wire logic        move_done_i,
	input  wire logic        move_addr_error_i,
	output logic             move_start_o,
	output logic [1:0]       move_channel_o,
	output logic [31:0]      move_src_o,
	output logic [31:0]      move_dst_o,
	output logic [2:0]       move_size_o,
	output logic             move_dual_o,
	output logic             move_to_device_o,
	output logic [3:0]       transfer_acknowledge_o,
	output logic [3:0]       end_of_transfer_irq_o,
	output logic             address_error_irq_o,
	output logic             irq_o
);
	typedef struct packed {
		logic [3:0][31:0]    src;
		logic [3:0][31:0]    dst;
		logic [3:0][CNT_W-1:0] cnt;
		logic [3:0][15:0]    ctl;
		logic [3:0]          latch;
		logic [3:0]          req_prev;
		logic                ge;
		logic                nmi_f;
		logic                ae_f;
		logic                pending_cancel_enable;
		logic [1:0]          pr;
		logic [1:0]          rr_last;
		logic [4:0]          ist;
		logic [4:0]          imsk;
		tcs_state_t          st;
		logic [1:0]          ch;
		logic                start;
		logic                ack_ph;
		logic [31:0]         rdata;
		logic                rvalid;
	} tcs_regs_t;

	tcs_regs_t cur_r;
	tcs_regs_t cur_nxt;

	logic [3:0] eligible;
	logic [3:0] want;
	logic [3:0] ext_level;
	logic [3:0] ext_edge;
	logic [3:0] is_ext;
	logic [3:0] blocked;
	logic [1:0] grant;
	logic       grant_v;
	logic [3:0] chan_hit;
	logic [1:0] order [4];

	// Per-channel request sensing, eligibility and wanting.
	for (genvar c = 0; c < TCS_NCH; c++) begin : g_ch
		logic [3:0] rs;
		logic       ds;
		assign rs = cur_r.ctl[c][TCS_CTL_RS +: 4];
		// sense select on 0 and 1
		assign ds = (c < 2) ? cur_r.ctl[c][TCS_CTL_DS] : 1'b0;
		assign is_ext[c] = (rs == TCS_RS_EXT_DUAL) ||
			(rs == TCS_RS_EXT_M2A) || (rs == TCS_RS_EXT_A2M);
		assign blocked[c] = cur_r.ctl[c][TCS_CTL_TE] | cur_r.nmi_f |
			cur_r.ae_f | standby_i | reset_i;
		assign ext_level[c] = is_ext[c] && !ds &&
			!external_request_n_i[c] && !blocked[c];
		assign ext_edge[c] = is_ext[c] && ds && cur_r.req_prev[c] &&
			!external_request_n_i[c] && !blocked[c];
		assign eligible[c] = cur_r.ctl[c][TCS_CTL_CE] & cur_r.ge &
			~cur_r.ctl[c][TCS_CTL_TE] & ~cur_r.nmi_f & ~cur_r.ae_f;
		assign want[c] = eligible[c] && (
			(rs == TCS_RS_AUTO) ||
			(is_ext[c] && (ext_level[c] || cur_r.latch[c])) ||
			(rs[3] && periph_request_i[c]));
	end

	// Priority order table from the mode field.
	always_comb begin
		case (cur_r.pr)
			2'd0: order = '{2'd0, 2'd1, 2'd2, 2'd3};
			2'd1: order = '{2'd0, 2'd2, 2'd3, 2'd1};
			2'd2: order = '{2'd2, 2'd0, 2'd1, 2'd3};
			default: order = '{2'(cur_r.rr_last + 2'd1),
				2'(cur_r.rr_last + 2'd2), 2'(cur_r.rr_last + 2'd3),
				cur_r.rr_last};
		endcase
	end

	always_comb begin
		grant = 2'd0;
		grant_v = 1'b0;
		for (int i = 3; i >= 0; i--) begin
			if (want[order[i]]) begin
				grant = order[i];
				grant_v = 1'b1;
			end
		end
	end

	// Address decode of the per-channel blocks.
	always_comb begin
		chan_hit = 4'h0;
		if (avs_address_i[7:6] == 2'b00) begin
			chan_hit[avs_address_i[5:4]] = 1'b1;
		end
	end

	// Next-state logic for the whole block.
	always_comb begin
		logic [31:0] wd;
		logic        wr;
		logic [3:0]  evt;
		wd = avs_writedata_i;
		wr = avs_write_i && !cur_r.rvalid;
		evt = 4'h0;
		cur_nxt = cur_r;
		cur_nxt.start = 1'b0;
		cur_nxt.req_prev = external_request_n_i;
		// latch edges while held off; accepted after reset
		for (int c = 0; c < TCS_NCH; c++) begin
			if (ext_edge[c]) begin
				cur_nxt.latch[c] = 1'b1;
			end
			// cancel with the cancel enable and sense cleared
			if (cur_r.pending_cancel_enable && !cur_r.ctl[c][TCS_CTL_DS] &&
				external_request_n_i[c]) begin
				cur_nxt.latch[c] = 1'b0;
			end
		end
		// Register writes; a zero clears end, NMI and AE flags, a one clears status bits.
		if (wr) begin
			for (int c = 0; c < TCS_NCH; c++) begin
				if (chan_hit[c]) begin
					case (avs_address_i[3:0])
						TCS_SRC_OFS[3:0]: cur_nxt.src[c] = wd;
						TCS_DST_OFS[3:0]: cur_nxt.dst[c] = wd;
						TCS_CNT_OFS[3:0]: cur_nxt.cnt[c] = wd[CNT_W-1:0];
						TCS_CTL_OFS[3:0]: begin
							cur_nxt.ctl[c] = wd[15:0];
							// End flag may only be cleared by software.
							cur_nxt.ctl[c][TCS_CTL_TE] =
								cur_r.ctl[c][TCS_CTL_TE] & wd[TCS_CTL_TE];
							// sense select falling clears edge latch
							if (cur_r.ctl[c][TCS_CTL_DS] && !wd[TCS_CTL_DS] &&
								external_request_n_i[c]) begin
								cur_nxt.latch[c] = 1'b0;
							end
						end
						default: ;
					endcase
				end
			end
			if (avs_address_i == TCS_OPC_ADDR) begin
				cur_nxt.ge = wd[TCS_OPC_GE];
				cur_nxt.pending_cancel_enable = wd[TCS_OPC_COD];
				cur_nxt.pr = wd[TCS_OPC_PR +: 2];
				cur_nxt.nmi_f = cur_r.nmi_f & wd[TCS_OPC_NMI];
				cur_nxt.ae_f = cur_r.ae_f & wd[TCS_OPC_AE];
			end else if (avs_address_i == TCS_IST_ADDR) begin
				cur_nxt.ist = cur_r.ist & ~wd[4:0];
			end else if (avs_address_i == TCS_IMSK_ADDR) begin
				cur_nxt.imsk = wd[4:0];
			end
		end
		// Transfer engine.
		case (cur_r.st)
			TCS_IDLE: begin
				// waits until enabled; start one unit
				if (grant_v) begin
					cur_nxt.ch = grant;
					cur_nxt.start = 1'b1;
					cur_nxt.ack_ph = 1'b1;
					cur_nxt.latch[grant] = 1'b0;
					cur_nxt.st = TCS_MOVE;
				end
			end
			TCS_MOVE: begin
				if (move_addr_error_i) begin
					cur_nxt.ae_f = 1'b1;
					evt[0] = 1'b1;
					cur_nxt.ack_ph = 1'b0;
					cur_nxt.st = TCS_IDLE;
				end else if (move_done_i) begin
					cur_nxt.cnt[cur_r.ch] = cur_r.cnt[cur_r.ch] - 1'b1;
					cur_nxt.rr_last = cur_r.ch;
					cur_nxt.ack_ph = 1'b0;
					cur_nxt.st = TCS_DONE;
				end
			end
			default: begin
				if (cur_r.cnt[cur_r.ch] == '0) begin
					cur_nxt.ctl[cur_r.ch][TCS_CTL_TE] = 1'b1;
					evt[cur_r.ch] = cur_r.ctl[cur_r.ch][TCS_CTL_IE];
				end
				cur_nxt.st = TCS_IDLE;
			end
		endcase
		if (nmi_i) begin
			cur_nxt.nmi_f = 1'b1;
		end
		if (cur_nxt.nmi_f || cur_nxt.ae_f) begin
			cur_nxt.latch = 4'h0;
		end
		// Sticky status: bit 0 address error, bits 4:1 channel ends.
		cur_nxt.ist = cur_nxt.ist |
			{evt[3:1] | 3'h0, 1'b0, 1'b0} | 5'h0;
		cur_nxt.ist[0] = cur_nxt.ist[0] | (evt[0] & cur_nxt.ae_f &
			!cur_r.ae_f);
		for (int c = 0; c < TCS_NCH; c++) begin
			if (cur_r.st == TCS_DONE && c == cur_r.ch &&
				cur_r.cnt[c] == '0 && cur_r.ctl[c][TCS_CTL_IE]) begin
				cur_nxt.ist[c+1] = 1'b1;
			end
		end
		// Read data, one wait state.
		cur_nxt.rvalid = (avs_read_i || avs_write_i) && !cur_r.rvalid;
		cur_nxt.rdata = 32'h0;
		if (avs_read_i) begin
			if (avs_address_i[7:6] == 2'b00) begin
				case (avs_address_i[3:0])
					TCS_SRC_OFS[3:0]: cur_nxt.rdata =
						cur_r.src[avs_address_i[5:4]];
					TCS_DST_OFS[3:0]: cur_nxt.rdata =
						cur_r.dst[avs_address_i[5:4]];
					TCS_CNT_OFS[3:0]: cur_nxt.rdata =
						32'(cur_r.cnt[avs_address_i[5:4]]);
					default: cur_nxt.rdata =
						{16'h0, cur_r.ctl[avs_address_i[5:4]]};
				endcase
			end else if (avs_address_i == TCS_OPC_ADDR) begin
				cur_nxt.rdata = {22'h0, cur_r.pr, 3'h0, cur_r.pending_cancel_enable, 1'b0,
					cur_r.ae_f, cur_r.nmi_f, cur_r.ge};
			end else if (avs_address_i == TCS_IST_ADDR) begin
				cur_nxt.rdata = {27'h0, cur_r.ist};
			end else if (avs_address_i == TCS_IMSK_ADDR) begin
				cur_nxt.rdata = {27'h0, cur_r.imsk};
			end else if (avs_address_i == TCS_EVT_ADDR) begin
				cur_nxt.rdata = {24'h0, cur_r.latch, eligible};
			end
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cur_r <= '0;
			cur_r.req_prev <= 4'hf;
			cur_r.st <= TCS_IDLE;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// Outputs.
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !cur_r.rvalid;
	assign avs_readdata_o = cur_r.rdata;
	assign move_start_o = cur_r.start;
	assign move_channel_o = cur_r.ch;
	assign move_src_o = cur_r.src[cur_r.ch];
	assign move_dst_o = cur_r.dst[cur_r.ch];
	assign move_size_o = cur_r.ctl[cur_r.ch][TCS_CTL_TS +: 3];
	assign move_dual_o = cur_r.ctl[cur_r.ch][TCS_CTL_RS +: 4] !=
		TCS_RS_EXT_M2A && cur_r.ctl[cur_r.ch][TCS_CTL_RS +: 4] !=
		TCS_RS_EXT_A2M;
	assign move_to_device_o = cur_r.ctl[cur_r.ch][TCS_CTL_RS +: 4] ==
		TCS_RS_EXT_M2A;
	assign transfer_acknowledge_o = cur_r.ack_ph ?
		(4'h1 << cur_r.ch) : 4'h0;
	assign end_of_transfer_irq_o = cur_r.ist[4:1] & cur_r.imsk[4:1];
	assign address_error_irq_o = cur_r.ist[0];
	assign irq_o = |(cur_r.ist & cur_r.imsk);
endmodule // tcs_sequencer

// File: verification/tcs_checker.sv
// Port checker for the transfer sequencer, bound to every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tcs_checker (
	input wire logic       mclk_i,
	input wire logic       reset_i,
	input wire logic       nmi_i,
	input wire logic       move_done_i,
	input wire logic       move_addr_error_i,
	input wire logic       move_start_o,
	input wire logic [1:0] move_channel_o,
	input wire logic [2:0] move_size_o,
	input wire logic [3:0] transfer_acknowledge_o,
	input wire logic [3:0] end_of_transfer_irq_o,
	input wire logic       address_error_irq_o
);
	// Every check uses the one clock and its reset.
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// A stopped engine starts nothing for eight cycles.
	sequence s_quiet;
		!move_start_o [*8];
	endsequence
	sequence s_gap;
		!move_start_o ##1 !move_start_o;
	endsequence
	property p_start;
		move_start_o |=> s_gap;
	endproperty
	property p_onehot;
		move_start_o |-> $onehot(transfer_acknowledge_o);
	endproperty
	property p_hold;
		|transfer_acknowledge_o && !move_done_i && !move_addr_error_i
			|=> $stable(move_channel_o) && $stable(move_size_o);
	endproperty
	property p_ack_end;
		$fell(|transfer_acknowledge_o)
			|-> $past(move_done_i) || $past(move_addr_error_i);
	endproperty
	property p_ae_irq;
		move_addr_error_i |-> ##[1:3] address_error_irq_o;
	endproperty
	property p_ae_stop;
		$rose(address_error_irq_o) |=> s_quiet;
	endproperty
	property p_nmi_stop;
		$rose(nmi_i) |-> ##2 s_quiet;
	endproperty
	property p_end_irq;
		$rose(|end_of_transfer_irq_o) |-> $past(move_done_i, 2);
	endproperty
	a_start: assert property (p_start)
		else $error("start pulses too close");
	a_onehot: assert property (p_onehot)
		else $error("acknowledge not one channel");
	a_hold: assert property (p_hold)
		else $error("unit fields changed mid unit");
	a_ack_end: assert property (p_ack_end)
		else $error("acknowledge dropped early");
	a_ae_irq: assert property (p_ae_irq)
		else $error("no address error interrupt");
	a_ae_stop: assert property (p_ae_stop)
		else $error("start after address error");
	a_nmi_stop: assert property (p_nmi_stop)
		else $error("start after nmi");
	a_end_irq: assert property (p_end_irq)
		else $error("end interrupt without unit done");
endmodule // tcs_checker
bind tcs_sequencer tcs_checker u_chk (
	.mclk_i(mclk_i), .reset_i(reset_i), .nmi_i(nmi_i),
	.move_done_i(move_done_i), .move_addr_error_i(move_addr_error_i),
	.move_start_o(move_start_o), .move_channel_o(move_channel_o),
	.move_size_o(move_size_o),
	.transfer_acknowledge_o(transfer_acknowledge_o),
	.end_of_transfer_irq_o(end_of_transfer_irq_o),
	.address_error_irq_o(address_error_irq_o)
);

// File: verification/tcs_mover_model.sv
// Model of the unit mover on the far side of the sequencer.
// Assumes one clock; answers each start after delay_i cycles.
`timescale 1ns/1ps
module tcs_mover_model (
	input  wire logic       mclk_i,
	input  wire logic       reset_i,
	input  wire logic       start_i,
	input  wire logic [3:0] delay_i,
	input  wire logic       fail_i,
	output logic            done_o,
	output logic            err_o
);
	logic [3:0] wait_r;
	always_ff @(posedge mclk_i) begin
		done_o <= 1'b0;
		err_o <= 1'b0;
		if (reset_i) begin
			wait_r <= 4'h0;
		end else if (start_i) begin
			wait_r <= delay_i;
		end else if (wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
			done_o <= (wait_r == 4'h1) && !fail_i;
			err_o <= (wait_r == 4'h1) && fail_i;
		end
	end
endmodule // tcs_mover_model

// File: verification/tcs_testbench.sv
// Self-checking bench for the transfer sequencer.
// Assumes the mover model and the bound checker are compiled first.
`timescale 1ns/1ps
module testbench;
	import tcs_pkg::*;
	typedef struct packed {
		logic [1:0] ch;
		logic [3:0] rs;
		logic [2:0] ts;
		logic       m;
		logic [4:0] info;
	} tcs_row_t;
	localparam tcs_row_t ROWS [5] = '{'{2'd0, 4'h0, 3'h2, 1'b1, 5'h12},
		'{2'd1, 4'h2, 3'h1, 1'b1, 5'h09}, '{2'd2, 4'h3, 3'h0, 1'b1, 5'h00},
		'{2'd3, 4'h4, 3'h3, 1'b0, 5'h03}, '{2'd0, 4'h8, 3'h4, 1'b0, 5'h04}};
	logic mclk_i, reset_i, avs_read_i, avs_write_i, nmi_i, standby_i, fail;
	logic move_done_i, move_addr_error_i, move_start_o, move_dual_o;
	logic move_to_device_o, address_error_irq_o, irq_o, avs_waitrequest_o;
	logic [1:0]  move_channel_o;
	logic [2:0]  move_size_o;
	logic [3:0]  external_request_n_i, periph_request_i, dly;
	logic [3:0]  transfer_acknowledge_o, end_of_transfer_irq_o;
	logic [4:0]  info;
	logic [7:0]  avs_address_i, hist, b;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd_q, move_src_o, move_dst_o;
	int          starts, n0, mismatches, comparisons;
	wire logic [4:0] irq_v = {end_of_transfer_irq_o, address_error_irq_o};
	tcs_sequencer dut (.mclk_i, .reset_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf),
		.avs_readdata_o, .avs_waitrequest_o, .external_request_n_i,
		.periph_request_i, .nmi_i, .standby_i, .move_done_i,
		.move_addr_error_i, .move_start_o, .move_channel_o, .move_src_o,
		.move_dst_o, .move_size_o, .move_dual_o, .move_to_device_o,
		.transfer_acknowledge_o, .end_of_transfer_irq_o,
		.address_error_irq_o, .irq_o);
	tcs_mover_model u_mover (.mclk_i, .reset_i, .start_i(move_start_o),
		.delay_i(dly), .fail_i(fail), .done_o(move_done_i),
		.err_o(move_addr_error_i));
	// Clock at 200 MHz and the watchdog.
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end
	// Counts unit starts, keeps channel history and the last unit mode.
	always @(posedge mclk_i) begin
		if (move_start_o === 1'b1) begin
			starts++;
			hist <= {hist[5:0], move_channel_o};
			info <= {move_dual_o, move_to_device_o, move_size_o};
		end
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// One Avalon access, held until waitrequest is seen low at an edge.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0 && ++n < 50);
		rd_q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n >= 50) mismatches++;
		@(posedge mclk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		compare(rd_q, e);
	endtask
	task automatic wait_irq(input int k);
		int n;
		n = 0;
		while (irq_v[k] !== 1'b1 && n < 400) begin
			@(posedge mclk_i);
			n++;
		end
		if (n >= 400) mismatches++;
	endtask
	// Reset, the row loop, then the awkward cases.
	initial begin
		{avs_read_i, avs_write_i, nmi_i, standby_i, fail} = 5'h00;
		{avs_address_i, avs_writedata_i, periph_request_i} = 44'h0;
		external_request_n_i = 4'hf;
		dly = 4'h1;
		reset_i = 1'b1;
		cyc(4);
		reset_i <= 1'b0;
		cyc(1);
		rdc(TCS_OPC_ADDR, 32'h0);
		rdc(TCS_CTL_OFS, 32'h0);
		wr(8'h80, 32'hffff_ffff);
		rdc(8'h80, 32'h0);
		wr(TCS_IMSK_ADDR, 32'h1f);
		wr(TCS_OPC_ADDR, 32'h1);
		foreach (ROWS[i]) begin
			b = {2'b00, ROWS[i].ch, 4'h0};
			n0 = starts;
			dly <= 4'(1 + 3 * i);
			wr(b + TCS_CNT_OFS, 32'h2);
			wr(b + TCS_CTL_OFS, {20'h0, ROWS[i].rs, 1'b0, ROWS[i].ts, 4'h5});
			external_request_n_i[ROWS[i].ch] <= ROWS[i].rs[3:2] != 2'b00;
			periph_request_i[ROWS[i].ch] <= ROWS[i].rs[3];
			wait_irq(ROWS[i].ch + 1);
			cyc(20);
			compare(starts - n0, 2);
			compare(ROWS[i].m ? info : {2'b00, info[2:0]}, ROWS[i].info);
			compare(irq_o, 1'b1);
			external_request_n_i <= 4'hf;
			periph_request_i <= 4'h0;
			wr(TCS_IST_ADDR, 32'h1f);
			compare(irq_o, 1'b0);
			wr(b + TCS_CTL_OFS, 32'h0);
		end
		// Two automatic channels become eligible together, masked.
		wr(TCS_OPC_ADDR, 32'h0);
		wr(TCS_IMSK_ADDR, 32'h0);
		wr(8'h18, 32'h1);
		wr(8'h28, 32'h1);
		wr(8'h1c, 32'h405);
		wr(8'h2c, 32'h405);
		wr(TCS_OPC_ADDR, 32'h201);
		cyc(40);
		compare(hist[3:0], 4'b1001);
		compare(irq_o, 1'b0);
		rdc(TCS_IST_ADDR, 32'hc);
		wr(TCS_IST_ADDR, 32'hc);
		wr(TCS_IMSK_ADDR, 32'h1f);
		// An edge held while disabled is served once, line kept low.
		n0 = starts;
		wr(TCS_OPC_ADDR, 32'h0);
		wr(TCS_CNT_OFS, 32'h2);
		wr(TCS_CTL_OFS, 32'h9);
		external_request_n_i[0] <= 1'b0;
		cyc(10);
		compare(starts - n0, 0);
		rdc(TCS_EVT_ADDR, 32'h10);
		wr(TCS_OPC_ADDR, 32'h1);
		cyc(20);
		compare(starts - n0, 1);
		external_request_n_i <= 4'hf;
		// NMI drops a held request.
		wr(TCS_OPC_ADDR, 32'h0);
		external_request_n_i[0] <= 1'b0;
		cyc(4);
		nmi_i <= 1'b1;
		cyc(1);
		nmi_i <= 1'b0;
		rdc(TCS_OPC_ADDR, 32'h2);
		rdc(TCS_EVT_ADDR, 32'h0);
		// Cancel a held request with the cancel enable set.
		external_request_n_i[0] <= 1'b1;
		wr(TCS_OPC_ADDR, 32'h10);
		external_request_n_i[0] <= 1'b0;
		cyc(4);
		wr(TCS_CTL_OFS, 32'h1);
		external_request_n_i[0] <= 1'b1;
		cyc(2);
		rdc(TCS_EVT_ADDR, 32'h0);
		n0 = starts;
		wr(TCS_OPC_ADDR, 32'h11);
		cyc(10);
		compare(starts - n0, 0);
		// Address error stops the channel and always interrupts.
		fail <= 1'b1;
		wr(8'h28, 32'h4);
		wr(8'h2c, 32'h401);
		wait_irq(0);
		cyc(10);
		compare(starts - n0, 1);
		compare(irq_o, 1'b1);
		rdc(TCS_OPC_ADDR, 32'h15);
		fail <= 1'b0;
		wr(8'h2c, 32'h0);
		wr(TCS_IST_ADDR, 32'h1);
		wr(TCS_OPC_ADDR, 32'h1);
		// Standby hides a level request until it ends.
		n0 = starts;
		standby_i <= 1'b1;
		wr(8'h38, 32'h1);
		wr(8'h3c, 32'h5);
		external_request_n_i[3] <= 1'b0;
		cyc(10);
		compare(starts - n0, 0);
		standby_i <= 1'b0;
		wait_irq(4);
		compare(starts - n0, 1);
		// An edge on channel 0 taken while disabled is held in the latch.
		wr(TCS_OPC_ADDR, 32'h0);
		wr(TCS_CTL_OFS, 32'h9);
		external_request_n_i <= 4'he;
		cyc(2);
		rdc(TCS_EVT_ADDR, 32'h10);
		// Cancel without the cancel enable: negate, sense 1-0-1.
		external_request_n_i <= 4'hf;
		wr(TCS_CTL_OFS, 32'h1);
		wr(TCS_CTL_OFS, 32'h9);
		rdc(TCS_EVT_ADDR, 32'h0);
		external_request_n_i <= 4'he;
		cyc(2);
		reset_i <= 1'b1;
		cyc(4);
		reset_i <= 1'b0;
		cyc(1);
		rdc(TCS_EVT_ADDR, 32'h0);
		print_verdict();
	end
endmodule // testbench
